// ### rtl/piu_prioritized_interrupt_unit.sv
/*
 * prioritized interrupt unit: one non-maskable and four maskable sources,
 * option register, edge latches, entry/return sequencing, three flag sets
 * and a two-deep program counter stack for the interrupted context.
 * assumes the core pulses instr_done at each instruction boundary and
 * return_from_interrupt when it retires that instruction; port pins and
 * other asynchronous inputs arrive unsynchronised.
 */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "piu_defines.svh"

module piu_prioritized_interrupt_unit (
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // core handshake
    input wire logic instr_done,
    input wire logic return_from_interrupt,
    input wire logic sleep_req,
    input wire logic opt_clear_busy,
    input wire logic [11:0] core_pc,
    input wire piu_pkg::piu_flags_t core_flags_in,
    input wire logic core_flags_we,
    output logic irq_take,
    output logic [11:0] irq_vector,
    output logic [11:0] ret_pc,
    output logic ret_valid,
    output piu_pkg::piu_flags_t core_flags,
    output piu_pkg::piu_ctx_t ctx_state,
    output logic sleep_skip,
    output logic wake_req,
    // event sources
    input wire piu_pkg::piu_events_t events,
    input wire piu_pkg::piu_event_en_t event_en,
    input wire logic nmi_pin_n,
    output logic [13:0] event_flags
);
    import piu_pkg::*;

    // ------------------------------------------------------------------
    // option register
    // ------------------------------------------------------------------
    logic [2:0] opt_ff;
    logic global_irq_enable;
    logic src2_edge_polarity;
    logic src1_level_select;

    // only the three live bits are stored; the rest have no function
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            opt_ff <= 3'h0;
        end else if (reg_wr && reg_addr == `PIU_OPT_ADDR) begin
            opt_ff <= {reg_wdata[`PIU_LES_BIT], reg_wdata[`PIU_ESB_BIT],
                       reg_wdata[`PIU_GEN_BIT]};
        end
    end
    assign global_irq_enable = opt_ff[0];
    assign src2_edge_polarity = opt_ff[1];
    assign src1_level_select = opt_ff[2];

    // write-only: reads return zero, one cycle later
    always_ff @(posedge mclk) begin
        reg_rdata <= 8'h00;
    end

    // ------------------------------------------------------------------
    // input synchronisers (pins are asynchronous)
    // ------------------------------------------------------------------
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;
    logic [NSYNC-1:0] clean_ff;

    assign raw_in = {~nmi_pin_n, events};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    s1_ff[gi] <= 1'b0;
                    s2_ff[gi] <= 1'b0;
                    s3_ff[gi] <= 1'b0;
                    clean_ff[gi] <= 1'b0;
                end else begin
                    s1_ff[gi] <= raw_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    // a change counts once two stages agree
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        clean_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    piu_events_t ev;
    logic nmi_level;
    assign ev = clean_ff[NSYNC-2:0];
    assign nmi_level = clean_ff[NSYNC-1];

    // ------------------------------------------------------------------
    // event gating and routing
    // ------------------------------------------------------------------
    logic [13:0] gated;
    logic line0, line1, line2, line3, line4;

    assign gated = {
        ev.supply_monitor & event_en.supply_monitor_irq_enable,
        ev.spi_done,
        ev.port_pins & event_en.port_irq_enable,
        ev.timer1_zero & event_en.timer_irq_enable,
        ev.timer2_zero & event_en.timer_irq_enable,
        ev.osc_event & event_en.osc_irq_enable,
        ev.adc_done & event_en.converter_irq_enable
    };

    assign line0 = gated[13] | nmi_level;
    assign line1 = gated[12];
    assign line2 = |gated[11:4];
    assign line3 = |gated[3:1];
    assign line4 = gated[0];

    // per-event poll flags
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            event_flags <= 12'h000;
        end else begin
            event_flags <= gated;
        end
    end

    // ------------------------------------------------------------------
    // edge detection and latches
    // ------------------------------------------------------------------
    logic line0_d_ff;
    logic line1_d_ff;
    logic line2_d_ff;
    logic nmi_lat_ff;
    logic src1_lat_ff;
    logic src2_lat_ff;
    logic [2:0] accept_sel;
    logic take_nmi;
    logic take_mask;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            line0_d_ff <= 1'b0;
            line1_d_ff <= 1'b0;
            line2_d_ff <= 1'b0;
        end else begin
            line0_d_ff <= line0;
            line1_d_ff <= line1;
            line2_d_ff <= line2;
        end
    end

    logic edge0, fall1, edge2;
    // request lines are high-true, as the gated events are, so a rising
    // line edge is a rising event edge; src2_edge_polarity selects the falling one
    assign edge0 = line0 & ~line0_d_ff;
    assign fall1 = line1 & ~line1_d_ff;
    assign edge2 = src2_edge_polarity ? (~line2 & line2_d_ff)
                                      : (line2 & ~line2_d_ff);

    // set wins over clear so an edge in the starting cycle is kept
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            nmi_lat_ff <= 1'b0;
        end else if (edge0) begin
            nmi_lat_ff <= 1'b1;
        end else if (take_nmi) begin
            nmi_lat_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            src1_lat_ff <= 1'b0;
        end else if (fall1 && !src1_level_select) begin
            src1_lat_ff <= 1'b1;
        end else if (take_mask && accept_sel == 3'd1) begin
            src1_lat_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            src2_lat_ff <= 1'b0;
        end else if (edge2) begin
            src2_lat_ff <= 1'b1;
        end else if (take_mask && accept_sel == 3'd2) begin
            src2_lat_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // arbitration at instruction boundaries
    // ------------------------------------------------------------------
    piu_ctx_t ctx_ff;
    piu_ctx_t prev_ctx_ff;
    logic mask_inhibit_ff;
    logic req1;
    logic [4:1] mreq;
    logic any_mask;

    assign req1 = src1_level_select ? line1 : src1_lat_ff;
    assign mreq = {line4, line3, src2_lat_ff, req1} &
                  {4{global_irq_enable}};
    assign any_mask = |mreq;

    // nmi ignores the inhibit; only an nmi already in service blocks it
    assign take_nmi = instr_done && nmi_lat_ff &&
                      ctx_ff != CTX_NMI;
    assign take_mask = instr_done && !take_nmi && any_mask &&
                       !mask_inhibit_ff &&
                       ctx_ff == CTX_NORMAL;

    always_comb begin
        if (mreq[1]) begin
            accept_sel = 3'd1;
        end else if (mreq[2]) begin
            accept_sel = 3'd2;
        end else if (mreq[3]) begin
            accept_sel = 3'd3;
        end else begin
            accept_sel = 3'd4;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_take <= 1'b0;
            irq_vector <= 12'h000;
        end else begin
            irq_take <= take_nmi | take_mask;
            if (take_nmi) begin
                irq_vector <= `PIU_VEC_SRC0;
            end else if (take_mask) begin
                unique case (accept_sel)
                    3'd1: irq_vector <= `PIU_VEC_SRC1;
                    3'd2: irq_vector <= `PIU_VEC_SRC2;
                    3'd3: irq_vector <= `PIU_VEC_SRC3;
                    default: irq_vector <= `PIU_VEC_SRC4;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // context, inhibit and pc stack
    // ------------------------------------------------------------------
    logic quirk_ff;
    logic [11:0] pc_stack_ff [0:1];
    logic sp_ff;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctx_ff <= CTX_NORMAL;
            prev_ctx_ff <= CTX_NORMAL;
            mask_inhibit_ff <= 1'b0;
            quirk_ff <= 1'b0;
        end else if (take_nmi) begin
            prev_ctx_ff <= ctx_ff;
            ctx_ff <= CTX_NMI;
        end else if (take_mask) begin
            ctx_ff <= CTX_IRQ;
            mask_inhibit_ff <= 1'b1;
            quirk_ff <= opt_clear_busy;
        end else if (return_from_interrupt && ctx_ff != CTX_NORMAL) begin
            if (ctx_ff == CTX_NMI) begin
                ctx_ff <= prev_ctx_ff;
            end else begin
                ctx_ff <= CTX_NORMAL;
                mask_inhibit_ff <= 1'b0;
                quirk_ff <= 1'b0;
            end
        end
    end

    // nmi over a maskable routine needs a second level
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sp_ff <= 1'b0;
            pc_stack_ff[0] <= 12'h000;
            pc_stack_ff[1] <= 12'h000;
        end else if (take_nmi || take_mask) begin
            pc_stack_ff[ctx_ff != CTX_NORMAL] <= core_pc;
            sp_ff <= (ctx_ff != CTX_NORMAL);
        end else if (return_from_interrupt && ctx_ff != CTX_NORMAL) begin
            sp_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ret_pc <= 12'h000;
            ret_valid <= 1'b0;
        end else begin
            ret_valid <= return_from_interrupt && ctx_ff != CTX_NORMAL;
            ret_pc <= pc_stack_ff[sp_ff];
        end
    end

    // ------------------------------------------------------------------
    // three flag pairs
    // ------------------------------------------------------------------
    piu_flags_t flags_ff [0:2];
    logic [1:0] flag_sel;

    // the quirk leaves the normal pair in use during a maskable routine
    assign flag_sel = (ctx_ff == CTX_IRQ && quirk_ff) ? 2'd0
                                                       : 2'(ctx_ff);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_ff[0] <= '0;
            flags_ff[1] <= '0;
            flags_ff[2] <= '0;
        end else if (core_flags_we) begin
            flags_ff[flag_sel] <= core_flags_in;
        end
    end
    assign core_flags = flags_ff[flag_sel];
    assign ctx_state = ctx_ff;

    // ------------------------------------------------------------------
    // sleep control
    // ------------------------------------------------------------------
    assign sleep_skip = sleep_req && (any_mask || nmi_lat_ff);
    assign wake_req = global_irq_enable &&
                      (any_mask || nmi_lat_ff);

endmodule : piu_prioritized_interrupt_unit

// ### rtl/piu_defines.svh
/*
 * constants for the prioritized interrupt unit: option register offset,
 * field positions, reset value and vector addresses.
 * assumes inclusion by bare name from the design file, the checker or the bench.
 */
`ifndef PIU_DEFINES_SVH
`define PIU_DEFINES_SVH

// ----------------------------------------------------------------------
// option register
// ----------------------------------------------------------------------
`define PIU_OPT_ADDR 8'hc8
`define PIU_OPT_RESET 8'h00
`define PIU_GEN_BIT 4
`define PIU_ESB_BIT 5
`define PIU_LES_BIT 6

// ----------------------------------------------------------------------
// vectors (12-bit program space)
// ----------------------------------------------------------------------
`define PIU_VEC_SRC0 12'hffc
`define PIU_VEC_SRC1 12'hff6
`define PIU_VEC_SRC2 12'hff4
`define PIU_VEC_SRC3 12'hff2
`define PIU_VEC_SRC4 12'hff0

// ----------------------------------------------------------------------
// quirk window: cycles of the 4-cycle immediate write
// ----------------------------------------------------------------------
`define PIU_QUIRK_CYCLES 3

`endif

// ### rtl/piu_pkg.sv
/*
 * types for the prioritized interrupt unit.
 * assumes piu_defines.svh is on the include path.
 */
package piu_pkg;

    // ------------------------------------------------------------------
    // flag context and event bundles
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CTX_NORMAL,
        CTX_IRQ,
        CTX_NMI
    } piu_ctx_t;

    typedef struct packed {
        logic carry;
        logic zero;
    } piu_flags_t;

    typedef struct packed {
        logic supply_monitor;
        logic spi_done;
        logic [7:0] port_pins;
        logic timer1_zero;
        logic timer2_zero;
        logic osc_event;
        logic adc_done;
    } piu_events_t;

    typedef struct packed {
        logic timer_irq_enable;
        logic converter_irq_enable;
        logic supply_monitor_irq_enable;
        logic osc_irq_enable;
        logic [7:0] port_irq_enable;
    } piu_event_en_t;

endpackage : piu_pkg

// ### tb/piu_prioritized_interrupt_unit_sva.sv
/* port checker for the prioritized interrupt unit.
   assumes one clock domain and a sync active-high reset. */
`timescale 1ns/1ps
`include "piu_defines.svh"
module piu_unit_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic instr_done,
    input wire logic return_from_interrupt,
    input wire logic irq_take,
    input wire logic [11:0] irq_vector,
    input wire logic ret_valid,
    input wire piu_pkg::piu_ctx_t ctx_state,
    input wire logic wake_req
);
    import piu_pkg::*;
    logic gen_ff;
    // ------------------------------------------------------------------
    // shadow of the global enable, since the register cannot be read
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gen_ff <= 1'b0;
        end else if (reg_wr && reg_addr == `PIU_OPT_ADDR) begin
            gen_ff <= reg_wdata[`PIU_GEN_BIT];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_accept;
        instr_done ##1 irq_take;
    endsequence
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    AST_TAKE_CAUSE: assert property (
        irq_take |-> $past(instr_done)) else $error("take off boundary");
    AST_TAKE_PULSE: assert property (
        irq_take |=> !irq_take) else $error("take longer than one cycle");
    AST_VEC_MAP: assert property (
        irq_take |-> irq_vector inside {`PIU_VEC_SRC0, `PIU_VEC_SRC1,
        `PIU_VEC_SRC2, `PIU_VEC_SRC3, `PIU_VEC_SRC4})
        else $error("vector outside map");
    AST_CTX_ENTRY: assert property (
        s_accept |-> ctx_state == ((irq_vector == `PIU_VEC_SRC0) ?
        CTX_NMI : CTX_IRQ)) else $error("wrong context on entry");
    AST_NO_NEST: assert property (
        irq_take && $past(ctx_state) == CTX_IRQ |->
        irq_vector == `PIU_VEC_SRC0) else $error("maskable nested");
    AST_GEN_BLOCK: assert property (
        irq_take && !$past(gen_ff) |-> irq_vector == `PIU_VEC_SRC0)
        else $error("maskable taken while disabled");
    AST_WAKE_GEN: assert property (
        wake_req |-> gen_ff) else $error("wake while disabled");
    AST_RET: assert property (
        return_from_interrupt && ctx_state != CTX_NORMAL |=> ret_valid)
        else $error("return not answered");
    AST_RET_CAUSE: assert property (
        ret_valid |-> $past(return_from_interrupt))
        else $error("stray return pulse");
    AST_INHIBIT_HOLD: assert property (
        $past(ctx_state) == CTX_IRQ && !$past(return_from_interrupt) |->
        ctx_state inside {CTX_IRQ, CTX_NMI})
        else $error("inhibit lifted early");
    AST_RDATA: assert property (
        reg_rd |=> reg_rdata == 8'h00) else $error("option readable");
endmodule : piu_unit_sva

bind piu_prioritized_interrupt_unit piu_unit_sva u_sva (.mclk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_done,
    .return_from_interrupt, .irq_take, .irq_vector, .ret_valid,
    .ctx_state, .wake_req);

// ### tb/piu_core_model.sv
/* core model: four-cycle instructions, pc, return on command.
   assumes the bench raises ret_cmd for one cycle per return. */
`timescale 1ns/1ps
module piu_core_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ret_cmd,
    input wire logic sleep_req,
    input wire logic irq_take,
    input wire logic [11:0] irq_vector,
    output logic instr_done,
    output logic return_from_interrupt,
    output logic [11:0] core_pc
);
    logic [1:0] phase_ff;
    logic ret_pend_ff;
    // a sleeping core retires no instruction, so no boundary is offered
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase_ff <= 2'h0;
        end else if (!sleep_req) begin
            phase_ff <= phase_ff + 2'h1;
        end
    end
    assign instr_done = (phase_ff == 2'h3) && !sleep_req;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            core_pc <= 12'h100;
        end else if (instr_done) begin
            core_pc <= core_pc + 12'h001;
        end else if (irq_take) begin
            core_pc <= irq_vector;
        end
    end
    // return retires mid-instruction, clear of the boundary pulse
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ret_pend_ff <= 1'b0;
            return_from_interrupt <= 1'b0;
        end else begin
            return_from_interrupt <= ret_pend_ff && phase_ff == 2'h1;
            ret_pend_ff <= ret_cmd | (ret_pend_ff & (phase_ff != 2'h1));
        end
    end
endmodule : piu_core_model

// ### tb/piu_prioritized_interrupt_unit_tb.sv
/* self-checking bench for the prioritized interrupt unit.
   assumes the checker is bound in and the core model drives boundaries. */
`timescale 1ns/1ps
`include "piu_defines.svh"
`define CHK(n, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("MISMATCH %s exp %h got %h", n, e, g); \
    end \
end
module piu_prioritized_interrupt_unit_tb;
    import piu_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_req = 1'b0;
    logic opt_clear_busy = 1'b0;
    logic core_flags_we = 1'b0;
    logic ret_cmd = 1'b0;
    logic nmi_pin_n = 1'b1;
    piu_flags_t core_flags_in = 2'h0;
    piu_events_t events = 14'h0;
    logic [13:0] event_flags;
    piu_event_en_t event_en = 12'hfff;
    logic instr_done, return_from_interrupt, irq_take, ret_valid;
    logic sleep_skip, wake_req;
    logic [11:0] core_pc, irq_vector, ret_pc;
    logic [7:0] reg_rdata;
    piu_flags_t core_flags;
    piu_ctx_t ctx_state;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    logic [11:0] pc_q[$];
    piu_prioritized_interrupt_unit dut (.mclk, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_done,
        .return_from_interrupt, .sleep_req, .opt_clear_busy, .core_pc,
        .core_flags_in, .core_flags_we, .irq_take, .irq_vector, .ret_pc,
        .ret_valid, .core_flags, .ctx_state, .sleep_skip, .wake_req,
        .events, .event_en, .nmi_pin_n, .event_flags);
    piu_core_model core (.mclk, .sys_rst, .ret_cmd, .sleep_req, .irq_take,
        .irq_vector, .instr_done, .return_from_interrupt, .core_pc);
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            finish_test();
        end
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task finish_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    // whole-byte writes only, never single bits
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task take(input logic [11:0] v, input piu_ctx_t c);
        int i;
        i = 0;
        while (irq_take !== 1'b1 && i < 60) begin
            @(posedge mclk);
            #1;
            i++;
        end
        `CHK("irq_take", 1'b1, irq_take)
        `CHK("irq_vector", v, irq_vector)
        `CHK("ctx_state", c, ctx_state)
        pc_q.push_back(core_pc - 12'h001);
    endtask : take
    task ret(input piu_ctx_t c);
        int i;
        logic [11:0] exp_pc;
        @(posedge mclk);
        ret_cmd <= 1'b1;
        @(posedge mclk);
        ret_cmd <= 1'b0;
        for (i = 0; i < 12 && ret_valid !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        exp_pc = pc_q.pop_back();
        `CHK("ret_pc", exp_pc, ret_pc)
        `CHK("ret_ctx", c, ctx_state)
    endtask : ret
    task none(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
            `CHK("no_take", 1'b0, irq_take)
        end
    endtask : none
    task nmi;
        @(posedge mclk);
        nmi_pin_n <= 1'b0;
        repeat (2) @(posedge mclk);
        nmi_pin_n <= 1'b1;
    endtask : nmi
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        reg_addr <= `PIU_OPT_ADDR;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rdata", 8'h00, reg_rdata)
        `CHK("ctx_rst", CTX_NORMAL, ctx_state)
        // held until sampled: level sources are not stored
        events.timer1_zero <= 1'b1;
        none(24);
        sleep_req <= 1'b1;
        nmi();
        repeat (8) @(posedge mclk);
        #1;
        `CHK("wake_off", 1'b0, wake_req)
        sleep_req <= 1'b0;
        take(`PIU_VEC_SRC0, CTX_NMI);
        ret(CTX_NORMAL);
        none(12);
        $display("test disabled done");
        events.adc_done <= 1'b1;
        wr(8'hc9, 8'h10);
        none(12);
        wr(`PIU_OPT_ADDR, 8'h10);
        take(`PIU_VEC_SRC3, CTX_IRQ);
        none(12);
        nmi();
        take(`PIU_VEC_SRC0, CTX_NMI);
        ret(CTX_IRQ);
        events.timer1_zero <= 1'b0;
        repeat (8) @(posedge mclk);
        ret(CTX_NORMAL);
        take(`PIU_VEC_SRC4, CTX_IRQ);
        events.adc_done <= 1'b0;
        repeat (8) @(posedge mclk);
        ret(CTX_NORMAL);
        $display("test priority done");
        wr(`PIU_OPT_ADDR, 8'hd0);
        events.spi_done <= 1'b1;
        events.timer1_zero <= 1'b1;
        take(`PIU_VEC_SRC1, CTX_IRQ);
        events.spi_done <= 1'b0;
        repeat (8) @(posedge mclk);
        ret(CTX_NORMAL);
        take(`PIU_VEC_SRC3, CTX_IRQ);
        events.timer1_zero <= 1'b0;
        repeat (8) @(posedge mclk);
        ret(CTX_NORMAL);
        $display("test level select done");
        for (int k = 0; k < 2; k++) begin
            wr(`PIU_OPT_ADDR, k ? 8'h3f : 8'h1f);
            // core parked so every edge is latched before a boundary
            sleep_req <= 1'b1;
            events.port_pins[0] <= 1'b1;
            repeat (6) @(posedge mclk);
            #1;
            `CHK("rise_seen", k == 0, sleep_skip)
            repeat (2) begin
                events.port_pins[0] <= 1'b0;
                events.spi_done <= 1'b1;
                repeat (2) @(posedge mclk);
                events.port_pins[0] <= 1'b1;
                events.spi_done <= 1'b0;
                repeat (2) @(posedge mclk);
            end
            events.port_pins[0] <= 1'b0;
            repeat (6) @(posedge mclk);
            sleep_req <= 1'b0;
            take(`PIU_VEC_SRC1, CTX_IRQ);
            ret(CTX_NORMAL);
            take(`PIU_VEC_SRC2, CTX_IRQ);
            ret(CTX_NORMAL);
            none(16);
        end
        $display("test edge done");
        event_en.converter_irq_enable <= 1'b0;
        events.adc_done <= 1'b1;
        none(16);
        sleep_req <= 1'b1;
        repeat (2) @(posedge mclk);
        event_en.converter_irq_enable <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        `CHK("sleep_skip", 1'b1, sleep_skip)
        `CHK("wake_on", 1'b1, wake_req)
        `CHK("event_flags", 14'h0001, event_flags)
        sleep_req <= 1'b0;
        take(`PIU_VEC_SRC4, CTX_IRQ);
        events.adc_done <= 1'b0;
        repeat (8) @(posedge mclk);
        ret(CTX_NORMAL);
        $display("test gating done");
        core_flags_in <= 2'h3;
        core_flags_we <= 1'b1;
        @(posedge mclk);
        core_flags_we <= 1'b0;
        #1;
        `CHK("flags_norm", 2'h3, core_flags)
        for (int k = 0; k < 2; k++) begin
            opt_clear_busy <= k[0];
            events.timer1_zero <= 1'b1;
            take(`PIU_VEC_SRC3, CTX_IRQ);
            `CHK("flags_irq", k ? 2'h3 : 2'h0, core_flags)
            opt_clear_busy <= 1'b0;
            events.timer1_zero <= 1'b0;
            repeat (8) @(posedge mclk);
            ret(CTX_NORMAL);
            `CHK("flags_back", 2'h3, core_flags)
        end
        $display("test flags done");
        finish_test();
    end
endmodule : piu_prioritized_interrupt_unit_tb
